// ---- parallel_io_pin.sv ----
// Purpose: One pin of the shared port: output muxes, open drain, input paths
// Assumes: Peripheral controls arrive synchronous to clk
// Notes:   Pin outputs and input views are registered, one clock behind inputs
`timescale 1ns/1ps
module parallel_io_pin
  import parallel_io_pkg::*;
#(
  parameter logic IMPLEMENTED = 1'b1,
  parameter logic OD_CAPABLE  = 1'b1,
  parameter logic INPUT_ONLY  = 1'b0,
  parameter logic ANA_CAPABLE = 1'b0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Port settings
  input  wire logic direction,
  input  wire logic latch,
  input  wire logic open_drain,
  input  wire logic analog_sel,
  // Sharing peripheral
  input  wire logic periph_enable,
  input  wire logic periph_out_en,
  input  wire logic periph_out_data,
  output logic      periph_in_data,
  // Pad
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe_n,
  // Sampled level for software
  output logic      pin_level
);

  logic periph_owns;
  logic port_drives;
  logic drive_req;
  logic drive_data;
  logic od_active;
  logic nxt_oe;
  logic nxt_out;

  always_comb begin
    // Input-only sharers never compete for the output path
    periph_owns = IMPLEMENTED & periph_enable & periph_out_en & ~INPUT_ONLY;
    port_drives = IMPLEMENTED & ~periph_owns & (direction == DIR_OUTPUT);
    drive_req   = periph_owns | port_drives;
    drive_data  = periph_owns ? periph_out_data : latch;
    od_active   = OD_CAPABLE & open_drain;
    if (od_active) begin
      // Drive low only; release the pad for a high level
      nxt_oe  = drive_req & ~drive_data;
      nxt_out = 1'b0;
    end else begin
      nxt_oe  = drive_req;
      nxt_out = drive_req & drive_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_oe_n <= 1'b1;
      pin_out  <= 1'b0;
    end else begin
      pin_oe_n <= ~nxt_oe;
      pin_out  <= nxt_out;
    end
  end

  // Peripheral input sees the pad only while the port is not driving it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      periph_in_data <= 1'b0;
    end else begin
      periph_in_data <= IMPLEMENTED & ~port_drives & pin_in;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_level <= 1'b0;
    end else begin
      pin_level <= IMPLEMENTED & ~(ANA_CAPABLE & analog_sel) & pin_in;
    end
  end

endmodule

// ---- parallel_io_pkg.sv ----
// Purpose: Shared constants for the shared parallel I/O port
// Assumes: 32-bit Avalon-MM data path, byte addressing, one word per register
// Notes:   Register values sit in the low bits of each word; upper bits read zero
package parallel_io_pkg;

  // Avalon-MM bus geometry
  localparam int BUS_W  = 32;
  localparam int BE_W   = BUS_W / 8;
  localparam int ADDR_W = 5;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_PIN_DIRECTION  = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_LATCH   = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL      = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_OPEN_DRAIN     = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_ANALOG_INPUT   = 5'h10;

  // Reset values, given per bit so they fit any port width
  localparam logic RST_DIRECTION_BIT  = 1'b1;
  localparam logic RST_LATCH_BIT      = 1'b0;
  localparam logic RST_OPEN_DRAIN_BIT = 1'b0;
  localparam logic RST_ANALOG_BIT     = 1'b0;

  // Pin direction encoding
  localparam logic DIR_INPUT  = 1'b1;
  localparam logic DIR_OUTPUT = 1'b0;

  // Bus reply when no register is decoded
  localparam logic [BUS_W-1:0] UNMAPPED_READ = 32'h0000_0000;

endpackage

// ---- pin_load_model.sv ----
// Purpose: Pad loads: pull-up on every pad plus an outside driver
// Assumes: Outside driver only used while the port floats the pad
// Notes:   A floating pad reads high through the pull-up
`timescale 1ns/1ps
module pin_load_model #(
  parameter int WIDTH = 16
) (
  // Port side
  input  wire logic [WIDTH-1:0] pin_out,
  input  wire logic [WIDTH-1:0] pin_oe_n,
  // Outside driver
  input  wire logic [WIDTH-1:0] ext_en,
  input  wire logic [WIDTH-1:0] ext_val,
  output logic [WIDTH-1:0]      pin_in
);
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ((ext_en & ext_val) | ~ext_en));
endmodule

// ---- port_checker.sv ----
// Purpose: Port-side assertions for the shared port
// Assumes: Masks equal those of the bound port
// Notes:   Pads are one clock behind their causes
`timescale 1ns/1ps
module port_checker
  import parallel_io_pkg::*;
#(
  parameter int               WIDTH        = 16,
  parameter logic [WIDTH-1:0] IMPL_MASK    = '1,
  parameter logic [WIDTH-1:0] OD_MASK      = '1,
  parameter logic [WIDTH-1:0] IN_ONLY_MASK = '0
) (
  input wire logic             clk,
  input wire logic             reset_n,
  input wire logic             read,
  input wire logic             write,
  input wire logic [BUS_W-1:0] readdata,
  input wire logic             waitrequest,
  input wire logic [WIDTH-1:0] periph_enable,
  input wire logic [WIDTH-1:0] periph_out_en,
  input wire logic [WIDTH-1:0] periph_out_data,
  input wire logic [WIDTH-1:0] periph_in_data,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] pin_out,
  input wire logic [WIDTH-1:0] pin_oe_n
);
  // Bits the peripheral owns; pp leaves out open-drain capable ones
  wire logic [WIDTH-1:0] own = periph_enable & periph_out_en & ~IN_ONLY_MASK & IMPL_MASK;
  wire logic [WIDTH-1:0] pp  = own & ~OD_MASK;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_wait; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
  property p_mux;
    $past(reset_n) |-> ((pin_oe_n | (pin_out ^ $past(periph_out_data))) & $past(pp)) == '0;
  endproperty
  a_mux: assert property (p_mux) else $error("peripheral not driving pad");
  property p_loop; (periph_in_data & ~pin_oe_n & ~$past(own)) == '0; endproperty
  a_loop: assert property (p_loop) else $error("port output looped back");
  property p_echo;
    $past(reset_n) |-> ((periph_in_data ^ $past(pin_in)) & IMPL_MASK
                        & ($past(own) | (pin_oe_n & ~OD_MASK))) == '0;
  endproperty
  a_echo: assert property (p_echo) else $error("peripheral input lost");
  property p_unimpl; ((~pin_oe_n | pin_out) & ~IMPL_MASK) == '0; endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented pad active");
  property p_drive; (pin_out & pin_oe_n) == '0; endproperty
  a_drive: assert property (p_drive) else $error("high data on floating pad");
  property p_rst; $rose(reset_n) |-> pin_oe_n == '1 && periph_in_data == '0; endproperty
  a_rst: assert property (p_rst) else $error("pads active out of reset");
  property p_rdata; read && !waitrequest |-> (readdata >> WIDTH) == '0; endproperty
  a_rdata: assert property (p_rdata) else $error("upper read bits set");
endmodule
bind shared_parallel_io_port port_checker #(.WIDTH(WIDTH), .IMPL_MASK(IMPL_MASK),
  .OD_MASK(OD_MASK), .IN_ONLY_MASK(IN_ONLY_MASK)) port_checker_i (.clk(clk),
  .reset_n(reset_n), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .periph_enable(periph_enable), .periph_out_en(periph_out_en),
  .periph_out_data(periph_out_data), .periph_in_data(periph_in_data), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n));

// ---- shared_parallel_io_port.sv ----
// Purpose: Shared parallel I/O port with Avalon-MM register access
// Assumes: Bus master holds each request until waitrequest is seen low
// Notes:   Every access completes at the second clock edge after it is presented
`timescale 1ns/1ps
module shared_parallel_io_port
  import parallel_io_pkg::*;
#(
  parameter int              WIDTH       = 16,
  parameter logic [WIDTH-1:0] IMPL_MASK   = '1,
  parameter logic [WIDTH-1:0] OD_MASK     = '1,
  parameter logic [WIDTH-1:0] IN_ONLY_MASK = '0,
  parameter logic [WIDTH-1:0] ANALOG_MASK = '0
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [BUS_W-1:0]  writedata,
  input  wire logic [BE_W-1:0]   byteenable,
  output logic [BUS_W-1:0]       readdata,
  output logic                   waitrequest,
  // Sharing peripherals
  input  wire logic [WIDTH-1:0]  periph_enable,
  input  wire logic [WIDTH-1:0]  periph_out_en,
  input  wire logic [WIDTH-1:0]  periph_out_data,
  output logic [WIDTH-1:0]       periph_in_data,
  // Pads
  input  wire logic [WIDTH-1:0]  pin_in,
  output logic [WIDTH-1:0]       pin_out,
  output logic [WIDTH-1:0]       pin_oe_n
);

  logic [WIDTH-1:0] pin_direction_reg_ff;
  logic [WIDTH-1:0] output_latch_reg_ff;
  logic [WIDTH-1:0] open_drain_control_reg_ff;
  logic [WIDTH-1:0] analog_input_pin_ff;
  logic [WIDTH-1:0] pin_level;
  logic             ack_ff;
  logic [BUS_W-1:0] readdata_ff;
  logic [BUS_W-1:0] nxt_readdata;
  logic             wr_take;
  logic             rd_start;

  // Place a port-wide value in the low bits of a bus word
  function automatic logic [BUS_W-1:0] widen(input logic [WIDTH-1:0] v);
    logic [BUS_W-1:0] r;
    r = '0;
    r[WIDTH-1:0] = v;
    return r;
  endfunction

  // Byte-lane merge of write data over the current register value
  function automatic logic [WIDTH-1:0] merge(input logic [WIDTH-1:0] old_v,
                                              input logic [BUS_W-1:0] new_v,
                                              input logic [BE_W-1:0]  be);
    logic [BUS_W-1:0] r;
    r = widen(old_v);
    for (int i = 0; i < BE_W; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r[WIDTH-1:0];
  endfunction

  // One wait cycle per access; the answer comes at the second edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (read | write) & ~ack_ff;
    end
  end

  assign waitrequest = (read | write) & ~ack_ff;
  assign wr_take     = write & ack_ff;
  assign rd_start    = read & ~ack_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_direction_reg_ff <= {WIDTH{RST_DIRECTION_BIT}};
    end else if (wr_take && address == OFS_PIN_DIRECTION) begin
      pin_direction_reg_ff <= merge(pin_direction_reg_ff, writedata, byteenable) | ~IMPL_MASK;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      output_latch_reg_ff <= {WIDTH{RST_LATCH_BIT}};
    end else if (wr_take && (address == OFS_OUTPUT_LATCH || address == OFS_PIN_LEVEL)) begin
      output_latch_reg_ff <= merge(output_latch_reg_ff, writedata, byteenable) & IMPL_MASK;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      open_drain_control_reg_ff <= {WIDTH{RST_OPEN_DRAIN_BIT}};
    end else if (wr_take && address == OFS_OPEN_DRAIN) begin
      open_drain_control_reg_ff <= merge(open_drain_control_reg_ff, writedata, byteenable)
                                   & OD_MASK & IMPL_MASK;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      analog_input_pin_ff <= {WIDTH{RST_ANALOG_BIT}};
    end else if (wr_take && address == OFS_ANALOG_INPUT) begin
      analog_input_pin_ff <= merge(analog_input_pin_ff, writedata, byteenable)
                             & ANALOG_MASK & IMPL_MASK;
    end
  end

  always_comb begin
    case (address)
      OFS_PIN_DIRECTION: nxt_readdata = widen(pin_direction_reg_ff & IMPL_MASK);
      OFS_OUTPUT_LATCH:  nxt_readdata = widen(output_latch_reg_ff & IMPL_MASK);
      OFS_PIN_LEVEL:     nxt_readdata = widen(pin_level);
      OFS_OPEN_DRAIN:    nxt_readdata = widen(open_drain_control_reg_ff);
      OFS_ANALOG_INPUT:  nxt_readdata = widen(analog_input_pin_ff);
      default:           nxt_readdata = UNMAPPED_READ;
    endcase
  end

  // Read data captured at the first edge and held through the answer cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      readdata_ff <= '0;
    end else if (rd_start) begin
      readdata_ff <= nxt_readdata;
    end
  end

  assign readdata = readdata_ff;

  for (genvar g = 0; g < WIDTH; g++) begin : g_pin
    parallel_io_pin #(
      .IMPLEMENTED (IMPL_MASK[g]),
      .OD_CAPABLE  (OD_MASK[g]),
      .INPUT_ONLY  (IN_ONLY_MASK[g]),
      .ANA_CAPABLE (ANALOG_MASK[g])
    ) u_pin (
      .clk             (clk),
      .reset_n         (reset_n),
      .direction       (pin_direction_reg_ff[g]),
      .latch           (output_latch_reg_ff[g]),
      .open_drain      (open_drain_control_reg_ff[g]),
      .analog_sel      (analog_input_pin_ff[g]),
      .periph_enable   (periph_enable[g]),
      .periph_out_en   (periph_out_en[g]),
      .periph_out_data (periph_out_data[g]),
      .periph_in_data  (periph_in_data[g]),
      .pin_in          (pin_in[g]),
      .pin_out         (pin_out[g]),
      .pin_oe_n        (pin_oe_n[g]),
      .pin_level       (pin_level[g])
    );
  end

endmodule

// ---- test_shared_parallel_io_port.sv ----
// Purpose: Self-checking bench for the shared port
// Assumes: Bit 15 absent, bits 0-3 open-drain and analog, bit 8 input-only
// Notes:   Pads checked three clocks after the last write
`timescale 1ns/1ps
module test_shared_parallel_io_port;
  import parallel_io_pkg::*;
  localparam logic [15:0] IMPL = 16'h7FFF;
  logic              clk, reset_n, read, write, waitrequest;
  logic [ADDR_W-1:0] address;
  logic [BE_W-1:0]   be;
  logic [BUS_W-1:0]  writedata, readdata, rd;
  logic [15:0]       pen, poe, pdat, pin_data, pin_in, pin_out, pin_oe_n, ext_en, ext_val;
  int                err_total, n_tests;
  shared_parallel_io_port #(.WIDTH(16), .IMPL_MASK(IMPL), .OD_MASK(16'h000F),
    .IN_ONLY_MASK(16'h0100), .ANALOG_MASK(16'h000F)) shared_parallel_io_port_i (
    .clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(be), .readdata(readdata),
    .waitrequest(waitrequest), .periph_enable(pen), .periph_out_en(poe),
    .periph_out_data(pdat), .periph_in_data(pin_data), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  pin_load_model #(.WIDTH(16)) pin_load_model_i (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    rd = readdata;
    chk("bus answer", 32'h0, 32'(n >= 40));
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  task automatic pchk(input logic [15:0] eo, input logic [15:0] ee);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("pin_out", 32'(eo), 32'(pin_out));
    chk("pin_oe_n", 32'(ee), 32'(pin_oe_n));
  endtask
  task automatic t_reset();
    chk("pin_oe_n", 32'h0000FFFF, 32'(pin_oe_n));
    rchk("direction", OFS_PIN_DIRECTION, 32'h00007FFF);
    rchk("open drain", OFS_OPEN_DRAIN, 32'h0);
    rchk("latch", OFS_OUTPUT_LATCH, 32'h0);
  endtask
  task automatic t_latch();
    bus(1'b1, OFS_OUTPUT_LATCH, 32'h0000A5A5);
    rchk("latch", OFS_OUTPUT_LATCH, 32'h000025A5);
    bus(1'b1, OFS_PIN_LEVEL, 32'h00001234);
    rchk("latch", OFS_OUTPUT_LATCH, 32'h00001234);
    be <= 4'h1;
    bus(1'b1, OFS_OUTPUT_LATCH, 32'h0000FFFF);
    be <= 4'hF;
    rchk("latch lane", OFS_OUTPUT_LATCH, 32'h000012FF);
    bus(1'b1, 5'h14, 32'hFFFFFFFF);
    rchk("unmapped", 5'h14, 32'h0);
    rchk("latch", OFS_OUTPUT_LATCH, 32'h000012FF);
  endtask
  task automatic t_dir();
    bus(1'b1, OFS_PIN_DIRECTION, 32'h0);
    pchk(16'h12FF, 16'h8000);
    rchk("level", OFS_PIN_LEVEL, 32'h000012FF);
    ext_en <= 16'hFFFF;
    ext_val <= 16'h5A5A;
    bus(1'b1, OFS_PIN_DIRECTION, 32'h0000FFFF);
    bus(1'b1, OFS_ANALOG_INPUT, 32'h0000FFFF);
    pchk(16'h0, 16'hFFFF);
    rchk("level", OFS_PIN_LEVEL, 32'h00005A50);
  endtask
  task automatic t_od();
    ext_en <= 16'h0;
    bus(1'b1, OFS_OPEN_DRAIN, 32'h0000FFFF);
    rchk("open drain", OFS_OPEN_DRAIN, 32'h0000000F);
    bus(1'b1, OFS_OUTPUT_LATCH, 32'h00000FF5);
    bus(1'b1, OFS_PIN_DIRECTION, 32'h0);
    pchk(16'h0FF0, 16'h8005);
  endtask
  task automatic t_rerst();
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    chk("pin_oe_n", 32'h0000FFFF, 32'(pin_oe_n));
    rchk("open drain", OFS_OPEN_DRAIN, 32'h0);
    rchk("direction", OFS_PIN_DIRECTION, 32'h00007FFF);
  endtask
  task automatic t_periph();
    bus(1'b1, OFS_OPEN_DRAIN, 32'h0);
    bus(1'b1, OFS_OUTPUT_LATCH, 32'h00000F0F);
    bus(1'b1, OFS_PIN_DIRECTION, 32'h000000F0);
    pen <= 16'hFFFF;
    poe <= 16'h01F0;
    pdat <= 16'h00A0;
    pchk(16'h0FAF, 16'h8000);
    chk("periph_in_data", 32'h000000A0, 32'(pin_data));
    rchk("level", OFS_PIN_LEVEL, 32'h00000FAF);
    poe <= 16'h0;
    pchk(16'h0F0F, 16'h80F0);
    ext_en <= 16'hFFFF;
    ext_val <= 16'h3C3C;
    bus(1'b1, OFS_PIN_DIRECTION, 32'h0000FFFF);
    pchk(16'h0, 16'hFFFF);
    chk("periph_in_data", 32'h00003C3C, 32'(pin_data));
  endtask
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    wrap_up();
  end
  initial begin
    {reset_n, read, write, address, writedata} = '0;
    {pen, poe, pdat, ext_en, ext_val} = '0;
    be = 4'hF;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_latch();
    t_dir();
    t_od();
    t_rerst();
    t_periph();
    wrap_up();
  end
endmodule
